// [dshp_host_port.sv]
/*
  dual-style parallel host port: data-strobe style with low acknowledge, or
  separate read/write strobes with a ready that rises on completion.
  assumes host pins synchronous to clk_sys and the pin wire resolved outside.
*/
`timescale 1ns/100ps
`include "dshp_params.svh"
module dshp_host_port #(
  parameter int AW = `DSHP_ADDR_W,
  parameter int DW = `DSHP_DATA_W,
  parameter int WORDS = `DSHP_MEM_WORDS,
  parameter int NSTREAM = 32,
  parameter int NHIZ = 16
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic bus_style_select,
  input wire logic port_select_n,
  input wire logic dir_or_write_strobe,
  input wire logic data_or_read_strobe,
  input wire logic [AW-1:0] host_word_address,
  input wire logic [DW-1:0] host_data_bus_in,
  output logic [DW-1:0] host_data_bus_out,
  output logic host_data_bus_oe,
  output logic transfer_ack_ready,
  output logic transfer_ack_ready_oe,
  output logic serial_out_streams_oe,
  output logic [NHIZ-1:0] ext_hiz_control
);
  localparam int ACC = `DSHP_ACCESS_CYC;
  logic rst_s1_r, rst_n_r;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // style strap caught after release so a floating strap settles first
  logic style_ds_r, style_ds_nxt, style_valid_r;
  always_comb begin
    style_ds_nxt = style_valid_r ? style_ds_r : bus_style_select;
  end
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      style_ds_r <= 1'b1;
      style_valid_r <= 1'b0;
    end else begin
      style_ds_r <= style_ds_nxt;
      style_valid_r <= 1'b1;
    end
  end

  logic sel, rd_req, wr_req;
  always_comb begin
    sel = 1'b0;
    rd_req = 1'b0;
    wr_req = 1'b0;
    if (!port_select_n) begin
      if (style_ds_r) begin
        sel = !data_or_read_strobe;
        rd_req = sel && dir_or_write_strobe;
        wr_req = sel && !dir_or_write_strobe;
      end else begin
        rd_req = !data_or_read_strobe;
        wr_req = !dir_or_write_strobe;
        sel = rd_req || wr_req;
      end
    end
  end

  dshp_pkg::dshp_state_t state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic is_rd_r, is_rd_nxt;
  logic [DW-1:0] rdata_r, rdata_nxt;
  logic [DW-1:0] store_rd;
  logic store_wr;

  dshp_store #(.WORDS(WORDS), .AW(AW), .DW(DW)) u_store (
    .clk_sys(clk_sys),
    .rst_n(rst_n_r),
    .wr_en(store_wr),
    .addr(host_word_address),
    .wr_data(host_data_bus_in),
    .rd_data(store_rd),
    .hit()
  );

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    is_rd_nxt = is_rd_r;
    rdata_nxt = rdata_r;
    store_wr = 1'b0;
    case (state_r)
      dshp_pkg::DSHP_IDLE: begin
        if (sel) begin
          state_nxt = dshp_pkg::DSHP_BUSY;
          cnt_nxt = 8'(ACC - 1);
          is_rd_nxt = rd_req;
        end
      end
      dshp_pkg::DSHP_BUSY: begin
        if (!sel) begin
          state_nxt = dshp_pkg::DSHP_IDLE;
        end else if (cnt_r == 8'h00) begin
          state_nxt = dshp_pkg::DSHP_DONE;
          store_wr = !is_rd_r && wr_req;
          rdata_nxt = store_rd;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      dshp_pkg::DSHP_DONE: begin
        if (!sel) begin
          state_nxt = dshp_pkg::DSHP_IDLE;
        end
      end
      default: state_nxt = dshp_pkg::DSHP_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= dshp_pkg::DSHP_IDLE;
      cnt_r <= 8'h00;
      is_rd_r <= 1'b0;
      rdata_r <= `DSHP_WORD_RESET;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      is_rd_r <= is_rd_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  logic done;
  assign done = (state_r == dshp_pkg::DSHP_DONE);
  assign host_data_bus_out = rdata_r;
  assign host_data_bus_oe = done && is_rd_r && rd_req;
  // data-strobe style: low ack while done, else released to the pull-up
  // strobe style: ready held low while busy, high once done
  always_comb begin
    if (!rst_n_r) begin
      transfer_ack_ready = 1'b1;
      transfer_ack_ready_oe = 1'b0;
    end else if (style_ds_r) begin
      transfer_ack_ready = 1'b0;
      transfer_ack_ready_oe = done;
    end else begin
      transfer_ack_ready = done;
      transfer_ack_ready_oe = (state_r != dshp_pkg::DSHP_IDLE);
    end
  end
  // stream drivers stay off and hiz controls high while reset holds
  assign serial_out_streams_oe = rst_n_r;
  assign ext_hiz_control = rst_n_r ? '0 : '1;

  // shadow count of busy cycles, kept apart from cnt_r so that a slip in the
  // down-counter cannot hide itself behind its own compare
  logic [7:0] busy_seen_r, busy_seen_nxt;
  always_comb begin
    busy_seen_nxt = 8'h00;
    if (state_r == dshp_pkg::DSHP_BUSY && busy_seen_r != 8'hff) begin
      busy_seen_nxt = busy_seen_r + 8'h01;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      busy_seen_r <= 8'h00;
    end else begin
      busy_seen_r <= busy_seen_nxt;
    end
  end

  // an access as the pins see it: taken from idle, then held through the
  // access time; the repeat count must follow the access count (four cycles)
  sequence s_ds_take;
    style_ds_r && state_r == dshp_pkg::DSHP_IDLE && sel;
  endsequence
  sequence s_rw_take;
    !style_ds_r && state_r == dshp_pkg::DSHP_IDLE && sel;
  endsequence
  sequence s_held;
    sel [*4];
  endsequence
  property p_ds_answer;
    s_ds_take ##1 s_held |=> !transfer_ack_ready && transfer_ack_ready_oe;
  endproperty
  property p_rw_answer;
    s_rw_take ##1 s_held |=> transfer_ack_ready && transfer_ack_ready_oe;
  endproperty

  chk_ack_after_sel: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    p_ds_answer)
    else $error("ack not low after access time");
  chk_ready_rises: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    (!style_ds_r && $rose(done)) |-> transfer_ack_ready && transfer_ack_ready_oe && !$past(transfer_ack_ready)
      && $past(transfer_ack_ready_oe))
    else $error("ready did not rise on completion");
  chk_idle_unsel: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    (port_select_n && state_r == dshp_pkg::DSHP_IDLE) |=> state_r == dshp_pkg::DSHP_IDLE)
    else $error("access started without select");
  chk_ds_gate: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    (style_ds_r && data_or_read_strobe) |-> !sel)
    else $error("data-strobe access without strobe");
  chk_write_lands: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    store_wr |-> wr_req && !port_select_n)
    else $error("write without write request");
  chk_read_drive: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    (done && is_rd_r && rd_req) |-> host_data_bus_oe && host_data_bus_out == rdata_r)
    else $error("read data not driven");
  chk_bus_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    (port_select_n || !done) |-> !host_data_bus_oe)
    else $error("data bus driven outside read");
  chk_style_held: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    style_valid_r |=> $stable(style_ds_r))
    else $error("style changed after strap");
  chk_reset_outs: assert property (@(posedge clk_sys)
    !rst_n_r |-> (ext_hiz_control == '1) && !serial_out_streams_oe)
    else $error("outputs active during reset");

  // answer timing and release
  chk_ready_after_sel: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    p_rw_answer)
    else $error("ready not high after access time");
  // strobe style drives the pin low itself while busy, so the pull-down is not trusted
  chk_ready_low_busy: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    s_rw_take |=> transfer_ack_ready_oe && !transfer_ack_ready)
    else $error("ready not held low while busy");
  chk_ack_not_early: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    s_ds_take |=> !transfer_ack_ready_oe [*4])
    else $error("ack driven before access time");
  chk_ds_ack_low: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    (style_ds_r && transfer_ack_ready_oe) |-> !transfer_ack_ready)
    else $error("ack driven high");
  chk_ack_idle_off: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    (state_r == dshp_pkg::DSHP_IDLE) |-> !transfer_ack_ready_oe)
    else $error("ack driven while idle");
  chk_busy_len: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    (state_r == dshp_pkg::DSHP_IDLE && sel)
      |=> state_r == dshp_pkg::DSHP_BUSY && cnt_r == 8'(ACC - 1))
    else $error("access not loaded with access time");
  // the shadow count bounds the busy stretch from both ends
  chk_busy_bound: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    (state_r == dshp_pkg::DSHP_BUSY) |-> busy_seen_r < 8'(ACC))
    else $error("access outlasts access time");
  chk_busy_full: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    (state_r == dshp_pkg::DSHP_DONE && $past(state_r) == dshp_pkg::DSHP_BUSY)
      |-> $past(busy_seen_r) == 8'(ACC - 1))
    else $error("access finished early");
  chk_done_release: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    (state_r == dshp_pkg::DSHP_DONE && !sel) |=> state_r == dshp_pkg::DSHP_IDLE && !host_data_bus_oe)
    else $error("access not released");

  // decode and data path
  chk_ds_dir: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    (style_ds_r && state_r == dshp_pkg::DSHP_IDLE && !port_select_n && !data_or_read_strobe)
      |=> state_r == dshp_pkg::DSHP_BUSY && is_rd_r == $past(dir_or_write_strobe))
    else $error("data-strobe direction not taken");
  chk_rw_write_take: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    (!style_ds_r && state_r == dshp_pkg::DSHP_IDLE && !port_select_n
      && !dir_or_write_strobe && data_or_read_strobe)
      |=> state_r == dshp_pkg::DSHP_BUSY && !is_rd_r)
    else $error("write strobe not taken as write");
  chk_rw_read_take: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    (!style_ds_r && state_r == dshp_pkg::DSHP_IDLE && !port_select_n
      && !data_or_read_strobe && dir_or_write_strobe)
      |=> state_r == dshp_pkg::DSHP_BUSY && is_rd_r)
    else $error("read strobe not taken as read");
  chk_write_once: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    store_wr |=> !store_wr)
    else $error("write repeated");
  // an address moved in the done cycle reads another word; that case is let through
  chk_write_data: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    (store_wr && host_word_address < AW'(WORDS))
      |=> host_word_address != $past(host_word_address) || store_rd == $past(host_data_bus_in))
    else $error("written word not stored");
  chk_read_word: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    (state_r == dshp_pkg::DSHP_BUSY && cnt_r == 8'h00 && sel && is_rd_r)
      |=> host_data_bus_out == $past(store_rd))
    else $error("read word not captured");
  chk_addr_range: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    (state_r == dshp_pkg::DSHP_BUSY && cnt_r == 8'h00 && sel && host_word_address >= AW'(WORDS))
      |=> host_data_bus_out == '0)
    else $error("unbacked address read nonzero");
  chk_no_drive_write: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    !is_rd_r |-> !host_data_bus_oe)
    else $error("data bus driven on write");

  // strap and reset
  // the strap is caught once, in the first cycle after release, from the pin as it stood at that edge
  chk_style_strap: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    !style_valid_r |=> style_ds_r == $past(bus_style_select))
    else $error("style not taken from strap");
  chk_hiz_run: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
    ext_hiz_control == '0 && serial_out_streams_oe)
    else $error("outputs held off after reset");
  chk_reset_state: assert property (@(posedge clk_sys)
    !rst_n_r |-> state_r == dshp_pkg::DSHP_IDLE && cnt_r == 8'h00 && host_data_bus_out == `DSHP_WORD_RESET)
    else $error("state not cleared in reset");
endmodule : dshp_host_port

// [dshp_params.svh]
/*
  constants for the dual-style host port: widths, timing counts, reset values.
  assumes a 100 MHz system clock; included by bare name.
*/
`ifndef DSHP_PARAMS_SVH
`define DSHP_PARAMS_SVH
`define DSHP_ADDR_W 14
`define DSHP_DATA_W 16
`define DSHP_MEM_WORDS 64
`define DSHP_WORD_RESET 16'h0000
`define DSHP_CLK_PERIOD_NS 10
`define DSHP_ACCESS_NS 40
`define DSHP_ACCESS_CYC ((`DSHP_ACCESS_NS + `DSHP_CLK_PERIOD_NS - 1) / `DSHP_CLK_PERIOD_NS)
`define DSHP_RESET_MIN_NS 1000
`define DSHP_FIRST_ACCESS_US 600
`define DSHP_FIRST_ACCESS_CYC (`DSHP_FIRST_ACCESS_US * 1000 / `DSHP_CLK_PERIOD_NS)
`endif

// [dshp_pkg.sv]
/*
  types shared by the dual-style host port.
  assumes nothing beyond the params header.
*/
package dshp_pkg;
  typedef enum logic [1:0] {
    DSHP_IDLE = 2'b00,
    DSHP_BUSY = 2'b01,
    DSHP_DONE = 2'b10
  } dshp_state_t;
endpackage : dshp_pkg

// [dshp_store.sv]
/*
  word storage behind the host port, flip-flops addressed by an index.
  assumes the caller writes one word per write pulse.
*/
`timescale 1ns/100ps
`include "dshp_params.svh"
module dshp_store #(
  parameter int WORDS = `DSHP_MEM_WORDS,
  parameter int AW = `DSHP_ADDR_W,
  parameter int DW = `DSHP_DATA_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wr_data,
  output logic [DW-1:0] rd_data,
  output logic hit
);
  logic [DW-1:0] mem_r [WORDS];
  logic [DW-1:0] mem_nxt [WORDS];
  // only the low words exist; higher addresses read zero and drop writes
  assign hit = (addr < AW'(WORDS));
  assign rd_data = hit ? mem_r[addr[$clog2(WORDS)-1:0]] : '0;
  genvar i;
  generate
    for (i = 0; i < WORDS; i++) begin : g_word
      always_comb begin
        mem_nxt[i] = mem_r[i];
        if (wr_en && hit && (addr[$clog2(WORDS)-1:0] == i)) begin
          mem_nxt[i] = wr_data;
        end
      end
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          mem_r[i] <= `DSHP_WORD_RESET;
        end else begin
          mem_r[i] <= mem_nxt[i];
        end
      end
    end
  endgenerate
endmodule : dshp_store

// [dshp_host_model.sv]
/*
  host processor model facing the dual-style host port.
  assumes clk_sys shared with the port and pin wires resolved by the bench.
*/
`timescale 1ns/100ps
module dshp_host_model #(
  parameter int WAIT_CYC = 60000
) (
  input wire logic clk_sys,
  input wire logic ds_style,
  input wire logic ack_w,
  input wire logic [15:0] data_w,
  output logic port_select_n,
  output logic dir_ws,
  output logic ds_rs,
  output logic [13:0] addr,
  output logic [15:0] wdata,
  output logic wdata_oe
);
  initial begin
    port_select_n = 1'b1;
    dir_ws = 1'b1;
    ds_rs = 1'b1;
    addr = 14'h0000;
    wdata = 16'h0000;
    wdata_oe = 1'b0;
  end
  task automatic settle();
    repeat (WAIT_CYC) @(posedge clk_sys);
    #1;
  endtask : settle
  // entered just after an edge; returns two cycles after release
  task automatic xfer(input logic rd, input logic [13:0] a, input logic [15:0] d,
                      output logic [15:0] q, output int lat);
    logic low_seen;
    low_seen = 1'b0;
    lat = 0;
    addr = a;
    wdata = d;
    wdata_oe = !rd;
    port_select_n = 1'b0;
    if (ds_style) begin
      dir_ws = rd;
      ds_rs = 1'b0;
    end else if (rd) begin
      ds_rs = 1'b0;
    end else begin
      dir_ws = 1'b0;
    end
    while (lat < 20) begin
      @(posedge clk_sys);
      #1;
      lat++;
      if (ack_w === 1'b0) low_seen = 1'b1;
      if (ds_style ? ack_w === 1'b0 : (low_seen && ack_w === 1'b1)) break;
    end
    q = data_w;
    port_select_n = 1'b1;
    dir_ws = 1'b1;
    ds_rs = 1'b1;
    wdata_oe = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : xfer
  // strobes alone, select left high
  task automatic strobes(input logic lvl, input logic [13:0] a);
    addr = a;
    wdata = 16'hffff;
    wdata_oe = !lvl;
    ds_rs = lvl;
    dir_ws = lvl;
  endtask : strobes
endmodule : dshp_host_model

// [dual_style_host_port_tb_top.sv]
/*
  self-checking bench for the dual-style host port, both bus styles.
  assumes the host model file and the design files compiled before it.
*/
`timescale 1ns/100ps
`include "dshp_params.svh"
module dual_style_host_port_tb_top;
  logic clk_sys, reset_n, strap, ps_n, dws, dsr, h_oe, d_oe, a_v, a_oe, so_oe;
  logic [13:0] a;
  logic [15:0] h_d, d_out, hiz, q;
  int n_fail, n_tests, cyc, lat;
  wire logic [15:0] data_w = h_oe ? h_d : (d_oe ? d_out : 16'hzzzz);
  // pull-up in data-strobe style, pull-down in strobe style
  wire logic ack_w = a_oe ? a_v : strap;
  dshp_host_port u_dshp_host_port (.clk_sys(clk_sys), .reset_n(reset_n), .bus_style_select(strap),
    .port_select_n(ps_n), .dir_or_write_strobe(dws), .data_or_read_strobe(dsr),
    .host_word_address(a), .host_data_bus_in(data_w), .host_data_bus_out(d_out),
    .host_data_bus_oe(d_oe), .transfer_ack_ready(a_v), .transfer_ack_ready_oe(a_oe),
    .serial_out_streams_oe(so_oe), .ext_hiz_control(hiz));
  // full first-access wait after every reset, both styles
  dshp_host_model #(.WAIT_CYC(`DSHP_FIRST_ACCESS_CYC)) u_dshp_host_model (.clk_sys(clk_sys), .ds_style(strap),
    .ack_w(ack_w), .data_w(data_w), .port_select_n(ps_n), .dir_ws(dws), .ds_rs(dsr),
    .addr(a), .wdata(h_d), .wdata_oe(h_oe));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic do_reset(input logic style);
    @(posedge clk_sys);
    #1;
    reset_n = 1'b0;
    strap = style;
    repeat (110) @(posedge clk_sys);
    #1;
    chk("stream oe in reset", 16'(so_oe), 16'h0000);
    chk("hiz in reset", hiz, 16'hffff);
    chk("oes in reset", 16'({d_oe, a_oe}), 16'h0000);
    reset_n = 1'b1;
    u_dshp_host_model.settle();
    chk("hiz after reset", hiz, 16'h0000);
    chk("stream oe after", 16'(so_oe), 16'h0001);
  endtask : do_reset
  task automatic t_rw(input logic [15:0] seed);
    logic [13:0] at[4];
    logic [15:0] w;
    at = '{14'h0000, 14'h003f, 14'h0040, 14'h3fff};
    for (int i = 0; i < 4; i++) begin
      w = seed ^ {2'b00, at[i]};
      u_dshp_host_model.xfer(1'b1, at[i], 16'h0000, q, lat);
      chk("word after reset", q, `DSHP_WORD_RESET);
      u_dshp_host_model.xfer(1'b0, at[i], w, q, lat);
      chk("write latency", 16'(lat), 16'(`DSHP_ACCESS_CYC + 1));
      chk("bus idle", 16'(d_oe), 16'h0000);
      u_dshp_host_model.xfer(1'b1, at[i], 16'h0000, q, lat);
      chk("read latency", 16'(lat), 16'(`DSHP_ACCESS_CYC + 1));
      chk("read word", q, at[i] < `DSHP_MEM_WORDS ? w : 16'h0000);
    end
  endtask : t_rw
  task automatic t_desel(input logic [15:0] exp);
    u_dshp_host_model.strobes(1'b0, 14'h003f);
    repeat (10) @(posedge clk_sys);
    #1;
    chk("deselected oes", 16'({d_oe, a_oe}), 16'h0000);
    u_dshp_host_model.strobes(1'b1, 14'h003f);
    @(posedge clk_sys);
    #1;
    u_dshp_host_model.xfer(1'b1, 14'h003f, 16'h0000, q, lat);
    chk("word kept", q, exp);
  endtask : t_desel
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 125000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    reset_n = 1'b0;
    strap = 1'b1;
    n_fail = 0;
    n_tests = 0;
    cyc = 0;
    do_reset(1'b1);
    t_rw(16'h5a00);
    t_desel(16'h5a3f);
    do_reset(1'b0);
    t_rw(16'hc300);
    t_desel(16'hc33f);
    wrap_up();
  end
endmodule : dual_style_host_port_tb_top
